// ===== clspid_top.sv
// Closed-loop speed regulator for two motor channels
`timescale 1ns/1ps
// Function
// - Three closed-loop modes; pair on their own commands or channel one.
// - Local panel path cannot select speed modes.
// - Mid-scale input reads as zero speed.
// - Input maps to signed plus/minus 127.
// - Each period error is desired minus measured.
// - Proportional gain times error drives output.
// - Error change times differential gain added.
// - Accumulated error times integral gain added.
// - One gain set shared by both channels.
// - Persistent shortfall ramps power to full.
// - Emergency stop halts drive regardless of loop.
// - Encoder speed may replace analog tachometer.
module clspid_top
   import clspid_pkg::*;
#(
   parameter int PERIOD = PERIOD_CYCLES
) (
   // Clock and reset
   input wire logic clk,
   input wire logic resetn,
   // Configuration from the host path
   input wire logic hostCfgWrite,
   input wire logic [2:0] hostMode,
   // Configuration from the local switch and display path
   input wire logic panelCfgWrite,
   input wire logic [2:0] panelMode,
   // Gains shared by both channels
   input wire logic [7:0] gainP,
   input wire logic [7:0] gainI,
   input wire logic [7:0] gainD,
   // Speed commands
   input wire logic signed [7:0] cmdSpeed0,
   input wire logic signed [7:0] cmdSpeed1,
   // Sensor selection and inputs
   input wire logic useEncoder,
   input wire logic [7:0] tachCode0,
   input wire logic [7:0] tachCode1,
   input wire logic signed [7:0] encSpeed0,
   input wire logic signed [7:0] encSpeed1,
   // Emergency stop pin, active low
   input wire logic estopN,
   // Outputs
   output logic signed [7:0] motorPower0,
   output logic signed [7:0] motorPower1,
   output logic [2:0] activeMode,
   output logic panelRefused,
   output logic periodTick
);
   localparam int CW = $clog2(PERIOD);
   localparam logic [CW-1:0] PERIOD_LAST = CW'(PERIOD - 1);

   logic [7:0] tachSync0; // Synchronised analog codes
   logic [7:0] tachSync1;
   logic estopSyncN; // Synchronised stop pin
   logic [CW-1:0] divCount; // Period divider
   logic tick;
   clspid_mode_t mode;
   logic signed [7:0] meas0;
   logic signed [7:0] meas1;
   logic signed [7:0] pid0;
   logic signed [7:0] pid1;
   logic en0;
   logic en1;
   logic panelIsSpeed;
   logic signed [7:0] desired1;

   // Pin inputs pass two flip-flops
   clspid_sync #(.W(16)) u_sync_tach (
      .clk(clk),
      .resetn(resetn),
      .din({tachCode1, tachCode0}),
      .dout({tachSync1, tachSync0})
   );
   clspid_sync #(.W(1)) u_sync_stop (
      .clk(clk),
      .resetn(resetn),
      .din(estopN),
      .dout(estopSyncN)
   );

   // Convert an analog code to signed speed, mid-scale is zero
   function automatic logic signed [7:0] tachToSpeed(input logic [7:0] code);
      logic signed [8:0] v;
      v = 9'({1'b0, code}) - 9'({1'b0, ADC_MID});
      // Code 0 would be -128; clamp to symmetric range
      if (v < 9'(SPEED_MIN)) begin
         tachToSpeed = SPEED_MIN;
      end else begin
         tachToSpeed = 8'(v);
      end
   endfunction

   // Select speed source per channel
   assign meas0 = useEncoder ? encSpeed0 : tachToSpeed(tachSync0);
   assign meas1 = useEncoder ? encSpeed1 : tachToSpeed(tachSync1);

   // Which channels run speed control
   assign en0 = (mode == CLSP_SEPARATE) || (mode == CLSP_MIXED) ||
                (mode == CLSP_SPEED_POS);
   assign en1 = (mode == CLSP_SEPARATE) || (mode == CLSP_MIXED);
   // Mixed mode: channel two takes its own command unchanged, as in separate mode
   assign desired1 = (mode == CLSP_MIXED) ? 8'sh00 + cmdSpeed1 : cmdSpeed1;
   assign panelIsSpeed = (panelMode == CLSP_SEPARATE) || (panelMode == CLSP_MIXED) ||
                         (panelMode == CLSP_SPEED_POS);

   // Control period divider
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         divCount <= '0;
         tick <= 1'b0;
      end else begin
         tick <= (divCount == PERIOD_LAST);
         divCount <= (divCount == PERIOD_LAST) ? '0 : divCount + CW'(1);
      end
   end

   // Mode register; host wins, panel cannot enter speed modes
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         mode <= clspid_mode_t'(MODE_RST);
         panelRefused <= 1'b0;
      end else begin
         panelRefused <= 1'b0;
         if (hostCfgWrite) begin
            mode <= clspid_mode_t'(hostMode);
         end else if (panelCfgWrite) begin
            if (panelIsSpeed) begin
               panelRefused <= 1'b1;
            end else begin
               mode <= clspid_mode_t'(panelMode);
            end
         end
      end
   end

   // Both channels share one gain set
   clspid_chan u_ch0 (
      .clk(clk),
      .resetn(resetn),
      .step(tick),
      .enable(en0),
      .desired(cmdSpeed0),
      .measured(meas0),
      .gainP(gainP),
      .gainI(gainI),
      .gainD(gainD),
      .power(pid0)
   );
   clspid_chan u_ch1 (
      .clk(clk),
      .resetn(resetn),
      .step(tick),
      .enable(en1),
      .desired(desired1),
      .measured(meas1),
      .gainP(gainP),
      .gainI(gainI),
      .gainD(gainD),
      .power(pid1)
   );

   // Output stage; stop overrides the loop
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         motorPower0 <= OUT_RST;
         motorPower1 <= OUT_RST;
         activeMode <= MODE_RST;
         periodTick <= 1'b0;
      end else begin
         motorPower0 <= estopSyncN ? pid0 : OUT_RST;
         motorPower1 <= estopSyncN ? pid1 : OUT_RST;
         activeMode <= mode;
         periodTick <= tick;
      end
   end

   // Assertions
   sequence stopSeen;
      !estopSyncN;
   endsequence
   chk_estop_halt: assert property (@(posedge clk) disable iff (!resetn)
      stopSeen |=> motorPower0 == 0 && motorPower1 == 0) else $error("drive during stop");
   chk_panel_refuse: assert property (@(posedge clk) disable iff (!resetn)
      panelCfgWrite && !hostCfgWrite && panelIsSpeed |=> $stable(mode) && panelRefused)
      else $error("panel entered speed mode");
   // Compare with the code offered at the write edge, not whatever follows it
   chk_host_mode: assert property (@(posedge clk) disable iff (!resetn)
      hostCfgWrite |=> mode == $past(hostMode)) else $error("host mode not taken");
   chk_ch1_off: assert property (@(posedge clk) disable iff (!resetn)
      mode == CLSP_SPEED_POS |=> pid1 == 0) else $error("channel two ran speed");
   chk_mid_zero: assert property (@(posedge clk) disable iff (!resetn)
      !useEncoder && tachSync0 == ADC_MID |-> meas0 == 0) else $error("mid not zero");
   chk_top_max: assert property (@(posedge clk) disable iff (!resetn)
      !useEncoder && tachSync0 == 8'hFF |-> meas0 == SPEED_MAX) else $error("top not max");
   chk_enc_sel: assert property (@(posedge clk) disable iff (!resetn)
      useEncoder |-> meas1 == encSpeed1) else $error("encoder not selected");
   chk_tick_once: assert property (@(posedge clk) disable iff (!resetn)
      tick |=> !tick) else $error("tick too long");
endmodule

// ===== clspid_pkg.sv
// Shared constants and types for the closed-loop speed regulator
package clspid_pkg;
   // Control period
   localparam int PERIOD_MS = 16;
   localparam int CLK_MHZ = 100;
   localparam int PERIOD_CYCLES = PERIOD_MS * 1000 * CLK_MHZ;
   // Analog converter width and mid-scale code
   localparam int ADC_W = 8;
   localparam logic [7:0] ADC_MID = 8'h80;
   // Speed value limits
   localparam logic signed [7:0] SPEED_MAX = 8'sh7F;
   localparam logic signed [7:0] SPEED_MIN = -8'sh7F;
   // Output limits
   localparam logic signed [15:0] OUT_MAX = 16'sh007F;
   localparam logic signed [15:0] OUT_MIN = -16'sh007F;
   // Integrator limit
   localparam logic signed [23:0] ACC_MAX = 24'sh0F_FFFF;
   // Reset values
   localparam logic signed [7:0] OUT_RST = 8'sh00;
   localparam logic [2:0] MODE_RST = 3'h0;
   // Motor control setting
   typedef enum logic [2:0] {
      CLSP_OPEN = 3'b000,
      CLSP_SEPARATE = 3'b001,
      CLSP_MIXED = 3'b010,
      CLSP_SPEED_POS = 3'b011,
      CLSP_POSITION = 3'b100
   } clspid_mode_t;
   // Sequencer states
   typedef enum logic [1:0] {
      ST_IDLE = 2'b00,
      ST_CH0 = 2'b01,
      ST_CH1 = 2'b10
   } clspid_state_t;
endpackage

// ===== clspid_sync.sv
// Two flip-flop synchroniser for a bus of pin inputs
`timescale 1ns/1ps
module clspid_sync #(
   parameter int W = 8
) (
   // Clock and reset
   input wire logic clk,
   input wire logic resetn,
   // Data
   input wire logic [W-1:0] din,
   output logic [W-1:0] dout
);
   logic [W-1:0] stage1; // Read only by the second stage

   // Two stages against metastability
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         stage1 <= '0;
         dout <= '0;
      end else begin
         stage1 <= din;
         dout <= stage1;
      end
   end
endmodule

// ===== clspid_chan.sv
// One channel of the PID speed computation
`timescale 1ns/1ps
module clspid_chan
   import clspid_pkg::*;
(
   // Clock and reset
   input wire logic clk,
   input wire logic resetn,
   // Control
   input wire logic step,
   input wire logic enable,
   // Speeds and gains
   input wire logic signed [7:0] desired,
   input wire logic signed [7:0] measured,
   input wire logic [7:0] gainP,
   input wire logic [7:0] gainI,
   input wire logic [7:0] gainD,
   // Result
   output logic signed [7:0] power
);
   logic signed [8:0] err; // Present error
   logic signed [8:0] prevErr; // Error of last period
   logic signed [9:0] diffErr; // Change of error
   logic signed [23:0] acc; // Accumulated error
   logic signed [23:0] next_acc;
   logic signed [31:0] termP;
   logic signed [31:0] termI;
   logic signed [31:0] termD;
   logic signed [33:0] sum;
   logic signed [33:0] scaled;
   logic signed [7:0] next_power;

   // Error and its change
   assign err = 9'(desired) - 9'(measured);
   assign diffErr = 10'(err) - 10'(prevErr);
   // Integrator, saturated so a stuck sensor keeps demanding power
   assign next_acc = (acc + 24'(err) > ACC_MAX) ? ACC_MAX :
                     (acc + 24'(err) < -ACC_MAX) ? -ACC_MAX : acc + 24'(err);
   // Terms with shared gains; integral scaled down since it dominates
   assign termP = 32'(err) * $signed({1'b0, gainP});
   assign termD = 32'(diffErr) * $signed({1'b0, gainD});
   assign termI = 32'(next_acc) * $signed({1'b0, gainI});
   assign sum = 34'(termP) + 34'(termD) + 34'(termI >>> 8);
   assign scaled = sum >>> 4;
   // Clamp to full forward and full reverse
   assign next_power = (scaled > 34'(OUT_MAX)) ? SPEED_MAX :
                       (scaled < 34'(OUT_MIN)) ? SPEED_MIN : 8'(scaled);

   // Update once per control period
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         prevErr <= '0;
         acc <= '0;
         power <= OUT_RST;
      end else if (!enable) begin
         // Clear history so re-entry starts clean
         prevErr <= '0;
         acc <= '0;
         power <= OUT_RST;
      end else if (step) begin
         prevErr <= err;
         acc <= next_acc;
         power <= next_power;
      end
   end

   chk_clamp_range: assert property (@(posedge clk) disable iff (!resetn)
      power <= SPEED_MAX && power >= SPEED_MIN) else $error("power out of range");
   chk_hold_off: assert property (@(posedge clk) disable iff (!resetn)
      !enable |=> power == OUT_RST) else $error("power not zero when off");
endmodule

// ===== clspid_plant_model.sv
// Behavioural speed sensor seen by the regulator: tachometer codes and encoder speeds
`timescale 1ns/1ps
module clspid_plant_model (
   // True motor speeds, signed
   input wire logic signed [7:0] speed0,
   input wire logic signed [7:0] speed1,
   // Tachometer wiring broken: reads mid-scale as if stopped
   input wire logic tachLost,
   // Sensor outputs
   output logic [7:0] tachCode0,
   output logic [7:0] tachCode1,
   output logic signed [7:0] encSpeed0,
   output logic signed [7:0] encSpeed1
);
   // Voltage proportional to speed: mid-scale stopped, top full forward
   assign tachCode0 = tachLost ? 8'h80 : 8'(speed0 + 8'sh80);
   assign tachCode1 = tachLost ? 8'h80 : 8'(speed1 + 8'sh80);
   // Encoder decoder keeps working when the tachometer is lost
   assign encSpeed0 = speed0;
   assign encSpeed1 = speed1;
endmodule

// ===== tb_closed_loop_speed_pid.sv
// Self-checking testbench for the two-channel speed regulator
`timescale 1ns/1ps
module tb_closed_loop_speed_pid;
   import clspid_pkg::*;
   // Clock, reset and stimulus
   logic clk, resetn, hostCfgWrite, panelCfgWrite, useEncoder, estopN, tachLost;
   logic [2:0] hostMode, panelMode, activeMode;
   logic [7:0] gainP, gainI, gainD, tachCode0, tachCode1;
   logic signed [7:0] cmdSpeed0, cmdSpeed1, encSpeed0, encSpeed1, speed0, speed1;
   logic signed [7:0] motorPower0, motorPower1, prevPower;
   logic panelRefused, periodTick;
   int failCount = 0;
   int totalChecks = 0;
   // Short period keeps the run small; run waits count in ticks, other waits in clock cycles
   clspid_top #(.PERIOD(20)) i_dut (.clk(clk), .resetn(resetn),
      .hostCfgWrite(hostCfgWrite), .hostMode(hostMode), .panelCfgWrite(panelCfgWrite),
      .panelMode(panelMode), .gainP(gainP), .gainI(gainI), .gainD(gainD),
      .cmdSpeed0(cmdSpeed0), .cmdSpeed1(cmdSpeed1), .useEncoder(useEncoder),
      .tachCode0(tachCode0), .tachCode1(tachCode1), .encSpeed0(encSpeed0),
      .encSpeed1(encSpeed1), .estopN(estopN), .motorPower0(motorPower0),
      .motorPower1(motorPower1), .activeMode(activeMode), .panelRefused(panelRefused),
      .periodTick(periodTick));
   clspid_plant_model i_plant (.speed0(speed0), .speed1(speed1), .tachLost(tachLost),
      .tachCode0(tachCode0), .tachCode1(tachCode1), .encSpeed0(encSpeed0),
      .encSpeed1(encSpeed1));
   // 100 MHz clock
   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end
   // Verdict and end of run
   task automatic wrapUp;
      if (failCount == 0 && totalChecks > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask
   // One comparison
   task automatic chk(input string nm, input logic [7:0] exp, input logic [7:0] got);
      totalChecks++;
      if (got !== exp) begin
         failCount++;
         $display("Error %s expected %h seen %h", nm, exp, got);
      end
   endtask
   // Let n periods pass, then stop where the outputs have settled
   task automatic run(input int n);
      int k;
      for (int i = 0; i < n; i++) begin
         k = 0;
         // Bounded wait for the period tick, looked at mid-cycle where it stands
         do begin
            @(negedge clk);
            k++;
         end while (periodTick !== 1'b1 && k < 100);
         if (periodTick !== 1'b1) begin
            failCount++;
            $display("Error periodTick expected 1 seen %b", periodTick);
            wrapUp();
         end
      end
      repeat (3) @(posedge clk);
      @(negedge clk);
   endtask
   // Configuration write from the host path
   task automatic hostSet(input logic [2:0] m);
      @(negedge clk);
      hostCfgWrite = 1'b1;
      hostMode = m;
      @(negedge clk);
      hostCfgWrite = 1'b0;
      @(negedge clk);
   endtask
   // Configuration write from the local panel path, refusal seen one cycle on
   task automatic panelSet(input logic [2:0] m, input logic refused);
      @(negedge clk);
      panelCfgWrite = 1'b1;
      panelMode = m;
      @(negedge clk);
      panelCfgWrite = 1'b0;
      chk("panelRefused", {7'h00, refused}, {7'h00, panelRefused});
      @(negedge clk);
   endtask
   // Gains and commands in one call
   task automatic setup(input logic [7:0] p, i, d, input logic signed [7:0] c0, c1, s0, s1);
      gainP = p;
      gainI = i;
      gainD = d;
      cmdSpeed0 = c0;
      cmdSpeed1 = c1;
      speed0 = s0;
      speed1 = s1;
   endtask
   // Main sequence
   initial begin
      resetn = 1'b0;
      {hostCfgWrite, panelCfgWrite, useEncoder, tachLost} = 4'h0;
      estopN = 1'b1;
      hostMode = 3'h0;
      panelMode = 3'h0;
      setup(8'h10, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00);
      repeat (16) @(posedge clk);
      @(negedge clk);
      resetn = 1'b1;
      // Panel cannot pick any speed mode, but may pick position
      for (int m = 1; m < 4; m++) begin
         panelSet(3'(m), 1'b1);
         chk("activeMode", 8'h00, {5'h00, activeMode});
      end
      panelSet(3'h4, 1'b0);
      chk("activeMode", 8'h04, {5'h00, activeMode});
      // Host selects the separate speed mode; proportional only, gain 16
      hostSet(CLSP_SEPARATE);
      chk("activeMode", 8'h01, {5'h00, activeMode});
      setup(8'h10, 8'h00, 8'h00, 8'h28, 8'hEC, 8'h0A, 8'h00);
      run(3);
      chk("motorPower0", 8'h1E, motorPower0);
      chk("motorPower1", 8'hEC, motorPower1);
      // Sensor extremes map to plus and minus 127; gain 16 cancels the scaling exactly
      setup(8'h10, 8'h00, 8'h00, 8'h00, 8'h00, 8'h7F, 8'h81);
      run(3);
      chk("motorPower0", 8'h81, motorPower0);
      chk("motorPower1", 8'h7F, motorPower1);
      // Large errors clamp to full forward and full reverse
      setup(8'hFF, 8'h00, 8'h00, 8'h28, 8'h9C, 8'h0A, 8'h64);
      run(3);
      chk("motorPower0", 8'h7F, motorPower0);
      chk("motorPower1", 8'h81, motorPower1);
      // Differential only: steady error gives zero, a step in error gives its change
      setup(8'h00, 8'h00, 8'h10, 8'h14, 8'h00, 8'h00, 8'h00);
      run(3);
      chk("motorPower0", 8'h00, motorPower0);
      cmdSpeed0 = 8'h32;
      run(1);
      chk("motorPower0", 8'h1E, motorPower0);
      run(1);
      chk("motorPower0", 8'h00, motorPower0);
      // Encoder feedback while the tachometer reads stopped
      tachLost = 1'b1;
      useEncoder = 1'b1;
      setup(8'h10, 8'h00, 8'h00, 8'h28, 8'h00, 8'h0A, 8'h00);
      run(3);
      chk("motorPower0", 8'h1E, motorPower0);
      // Lost sensor with integral only: power creeps up to full and never falls
      useEncoder = 1'b0;
      setup(8'h00, 8'hFF, 8'h00, 8'h64, 8'h00, 8'h00, 8'h00);
      // Pass through open loop so the integrator starts from an empty history
      hostSet(CLSP_OPEN);
      hostSet(CLSP_SEPARATE);
      prevPower = 8'sh00;
      for (int n = 0; n < 40; n++) begin
         run(1);
         if (motorPower0 < prevPower) begin
            chk("motorPower0", prevPower, motorPower0);
         end
         prevPower = motorPower0;
      end
      chk("motorPower0", 8'h7F, motorPower0);
      // Emergency stop overrides the demand within four cycles
      estopN = 1'b0;
      repeat (4) @(negedge clk);
      chk("motorPower0", 8'h00, motorPower0);
      estopN = 1'b1;
      // Speed plus position: second channel gets no speed drive
      tachLost = 1'b0;
      setup(8'h10, 8'h00, 8'h00, 8'h28, 8'h28, 8'h0A, 8'h0A);
      hostSet(CLSP_SPEED_POS);
      run(3);
      chk("motorPower0", 8'h1E, motorPower0);
      chk("motorPower1", 8'h00, motorPower1);
      hostSet(CLSP_MIXED);
      run(3);
      chk("motorPower1", 8'h1E, motorPower1);
      // Reset in mid-run clears drive and returns to open loop
      resetn = 1'b0;
      @(negedge clk);
      chk("motorPower1", 8'h00, motorPower1);
      chk("activeMode", 8'h00, {5'h00, activeMode});
      resetn = 1'b1;
      run(1);
      chk("motorPower1", 8'h00, motorPower1);
      wrapUp();
   end
endmodule
